// ==== dev_ctl_model.sv ====
/*
  Behavioural model of one device control unit on the request lines.
  Assumes the bench sets the assignment code and the need level.
*/
`default_nettype none
module dev_ctl_model (
  // assignment and demand
  input wire logic [2:0] assign_in,
  input wire logic need_in,
  // request lines, bit 0 is channel 1
  output prio_irq_pkg::ch_vec_t line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // gated decoder: code 0 drives no line, 1..7 one line each
  always_comb
  begin
    line_out = '0;
    if (need_in && assign_in != 3'h0)
    begin
      line_out[assign_in - 3'h1] = 1'b1;
    end
  end
endmodule : dev_ctl_model
`default_nettype wire

// ==== prio_chain.sv ====
/*
  Combinational priority chain over request and hold flags.
  Assumes flag vectors come from registers in the controller.
*/
`default_nettype none
`include "prio_irq_cfg.svh"
module prio_chain (
  // chain enable
  input wire logic active_in,
  // flag state
  input wire prio_irq_pkg::ch_vec_t req_in,
  input wire prio_irq_pkg::ch_vec_t hold_in,
  // results
  output prio_irq_pkg::ch_vec_t honored_out,
  output prio_irq_pkg::ch_vec_t dismiss_out,
  output logic any_out,
  output logic [`CH_CODE_W-1:0] code_out
);
  logic [`NUM_CH:0] en;
  logic [`NUM_CH:0] clr_en;

  assign en[0] = active_in;
  assign clr_en[0] = 1'b1;

  // stage n is enabled only if all higher stages are idle
  genvar i;
  generate
    for (i = 0; i < `NUM_CH; i++)
    begin : g_stage
      assign honored_out[i] = en[i] & ~hold_in[i] & req_in[i];
      assign en[i+1] = en[i] & ~hold_in[i] & ~req_in[i];
      // clear holds down to and including the first set one
      assign dismiss_out[i] = clr_en[i];
      assign clr_en[i+1] = clr_en[i] & ~hold_in[i];
    end
  endgenerate

  // any-request level and binary channel code
  always_comb
  begin
    code_out = '0;
    for (int k = `NUM_CH - 1; k >= 0; k--)
    begin
      if (honored_out[k])
        code_out = 3'(k + 1);
    end
  end
  assign any_out = |honored_out;
endmodule : prio_chain
`default_nettype wire

// ==== prio_irq.sv ====
/*
  Seven-channel priority interrupt controller: on, request and hold
  flags per channel, break cycle and block-done flags, condition-out
  and condition-in decoding on device code 004.
  Assumes the processor supplies single-cycle step pulses
  synchronous to mclk_in and a 36-bit bus word with each command.
*/
`default_nettype none
`include "prio_irq_cfg.svh"
// Behaviour
// - seven channels, channel 1 highest priority
// - sample requests at instruction/address cycle starts
// - honored channel n vectors to 40+2n
// - break cycle blocks sampling and new breaks
// - unfinished block: hold set, cleared, cycle ends
// - otherwise vector 41+2n, hold, clear flags
// - on, request, hold flag per channel
// - bus bits 29..35 select channels 1..7
// - strobe sets request if on and line
// - program request sets request flags directly
// - chain honors lowest pending channel when active
// - hold blocks lower stages, keeps request clear
// - higher channels still interrupt held break
// - dismiss clears holds through first set
// - device 004; status shows active and on
// - bit 23 clear phase resets all flags and the break state; brk_ch keeps its value
// - bit 28 sets active, 27 clears
// - 25 on, 26 off, 24 request selected
// - any-request level and channel code out
// - overflow sets block-done; hold kept then
// - block move strobe per word, no break
module prio_irq (
  // clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // device request lines, bit 0 is channel 1
  input wire prio_irq_pkg::ch_vec_t dev_req_in,
  // io instruction
  input wire logic [`DEV_CODE_W-1:0] dev_code_in,
  input wire logic condition_out_command_clear_in,
  input wire logic condition_out_command_set_in,
  input wire logic condition_in_command_in,
  input wire logic [`BUS_W-1:0] bus_data_in,
  output logic [`BUS_W-1:0] bus_data_out,
  output logic bus_data_oe_out,
  // processor sequencing pulses
  input wire logic instr_start_in,
  input wire logic addr_start_in,
  input wire logic delayed_sync_in,
  input wire logic block_step_in,
  input wire logic block_to_data_in,
  input wire logic index_overflow_in,
  input wire logic block_not_done_in,
  input wire logic exec_step_zero_in,
  input wire logic exec_step_one_in,
  input wire logic exec_step_ten_in,
  input wire logic hold_dismiss_in,
  // status toward processor
  output logic any_request_out,
  output logic [`CH_CODE_W-1:0] channel_code_out,
  output logic [`VEC_W-1:0] vector_out,
  output logic [`VEC_W-1:0] second_vector_out,
  output logic break_entry_out,
  output logic block_end_out,
  output logic break_cycle_out,
  output logic block_done_out,
  output logic system_active_out,
  output prio_irq_pkg::ch_vec_t honored_request_out,
  output prio_irq_pkg::ch_vec_t channel_on_out,
  output prio_irq_pkg::ch_vec_t channel_hold_out
);
  // reset release
  logic rst_s1, rst_n;
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // assertion clock and reset for every check below
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n);
  prio_irq_pkg::ch_vec_t req_sync_v;
  req_sync req_sync_i (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n),
    .raw_in(dev_req_in), // one line per requester assumed
    .sync_out(req_sync_v)
  );

  // flag state
  prio_irq_pkg::ch_vec_t channel_on_flag;
  prio_irq_pkg::ch_vec_t channel_request_latch;
  prio_irq_pkg::ch_vec_t channel_hold_flag;
  logic system_active_flag;
  logic break_cycle_flag;
  logic block_done_flag;
  prio_irq_pkg::brk_state_t state;
  logic [`CH_CODE_W-1:0] brk_ch;
  prio_irq_pkg::ch_vec_t next_on;
  prio_irq_pkg::ch_vec_t next_req;
  prio_irq_pkg::ch_vec_t next_hold;
  logic next_active, next_cyc, next_done;
  prio_irq_pkg::brk_state_t next_state;
  logic [`CH_CODE_W-1:0] next_brk_ch;
  logic [`BUS_W-1:0] next_bus;
  logic next_oe;

  // chain
  prio_irq_pkg::ch_vec_t honored;
  prio_irq_pkg::ch_vec_t dismiss_mask;
  logic any_req;
  logic [`CH_CODE_W-1:0] code;
  prio_chain prio_chain_i (
    .active_in(system_active_flag),
    .req_in(channel_request_latch),
    .hold_in(channel_hold_flag),
    .honored_out(honored),
    .dismiss_out(dismiss_mask),
    .any_out(any_req),
    .code_out(code)
  );

  // command decode
  logic selected;
  prio_irq_pkg::condition_out_command_t cmd;
  assign selected = (dev_code_in == `PI_DEV_CODE);
  always_comb
  begin
    cmd.clear_all = bus_data_in[`BIT_RESET];
    cmd.req = bus_data_in[`BIT_REQ];
    cmd.on = bus_data_in[`BIT_ON];
    cmd.off = bus_data_in[`BIT_OFF];
    cmd.act_clr = bus_data_in[`BIT_ACT_CLR];
    cmd.act_set = bus_data_in[`BIT_ACT_SET];
    // bus bit 29 is channel 1 ... bit 35 is channel 7
    for (int k = 0; k < `NUM_CH; k++)
      cmd.sel[k] = bus_data_in[`BIT_SEL_LO + k];
  end

  logic system_clear_pulse, condition_set_pulse, request_check_pulse;
  logic request_strobe, break_entry_pulse, hold_set_pulse, block_hold;
  assign system_clear_pulse = selected & condition_out_command_clear_in & cmd.clear_all;
  assign condition_set_pulse = selected & condition_out_command_set_in;
  // sampling at cycle starts and at each block-move word
  assign request_check_pulse = instr_start_in | addr_start_in
    | block_step_in;
  assign request_strobe = request_check_pulse & ~break_cycle_flag;
  // no break entry during a block move word; block ends instead
  assign break_entry_pulse = delayed_sync_in & any_req
    & ~break_cycle_flag & ~block_step_in;
  assign block_end_out = block_step_in & any_req & ~break_cycle_flag;
  assign block_hold = block_not_done_in & ~block_done_flag;
  assign hold_set_pulse = exec_step_zero_in & break_cycle_flag;

  // next-state logic for flags and break sequence
  always_comb
  begin
    next_on = channel_on_flag;
    next_req = channel_request_latch;
    next_hold = channel_hold_flag;
    next_active = system_active_flag;
    next_cyc = break_cycle_flag;
    next_done = block_done_flag;
    next_state = state;
    next_brk_ch = brk_ch;
    next_bus = '0;
    next_oe = 1'b0;
    // device requests only on channels that are on
    if (request_strobe)
      next_req = next_req | (req_sync_v & channel_on_flag);
    if (condition_set_pulse)
    begin
      if (cmd.act_set)
        next_active = 1'b1;
      if (cmd.act_clr)
        next_active = 1'b0;
      if (cmd.on)
        next_on = next_on | cmd.sel;
      if (cmd.off)
        next_on = next_on & ~cmd.sel;
      if (cmd.req)
        next_req = next_req | cmd.sel;
    end
    case (state)
      prio_irq_pkg::IDLE:
      begin
        if (break_entry_pulse)
        begin
          next_cyc = 1'b1;
          next_brk_ch = code;
          next_state = prio_irq_pkg::IN_BREAK;
        end
      end
      prio_irq_pkg::IN_BREAK:
      begin
        if (block_to_data_in & index_overflow_in)
          next_done = 1'b1;
        // hold the honored channel; step one drops it again for an unfinished block
        if (hold_set_pulse)
          next_hold = next_hold | honored;
        if (exec_step_one_in & block_hold)
          next_hold = next_hold & ~dismiss_mask;
        if (exec_step_ten_in)
        begin
          next_cyc = 1'b0;
          next_done = 1'b0;
          next_state = prio_irq_pkg::IDLE;
        end
      end
      default:
        next_state = prio_irq_pkg::IDLE;
    endcase
    if (hold_dismiss_in)
      next_hold = next_hold & ~dismiss_mask;
    // a held channel keeps its request clear
    next_req = next_req & ~next_hold;
    if (selected & condition_in_command_in)
    begin
      next_bus[`STAT_ACT_BIT] = system_active_flag;
      for (int k = 0; k < `NUM_CH; k++)
        next_bus[`BIT_SEL_LO + k] = channel_on_flag[k];
      next_oe = 1'b1;
    end
    if (system_clear_pulse)
    begin
      next_on = '0;
      next_req = '0;
      next_hold = '0;
      next_active = 1'b0;
      next_cyc = 1'b0;
      next_done = 1'b0;
      next_state = prio_irq_pkg::IDLE;
    end
  end

  // flag registers
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      channel_on_flag <= '0;
      channel_request_latch <= '0;
      channel_hold_flag <= '0;
      system_active_flag <= 1'b0;
      break_cycle_flag <= 1'b0;
      block_done_flag <= 1'b0;
      state <= prio_irq_pkg::IDLE;
      brk_ch <= '0;
      bus_data_out <= '0;
      bus_data_oe_out <= 1'b0;
    end
    else
    begin
      channel_on_flag <= next_on;
      channel_request_latch <= next_req;
      channel_hold_flag <= next_hold;
      system_active_flag <= next_active;
      break_cycle_flag <= next_cyc;
      block_done_flag <= next_done;
      state <= next_state;
      brk_ch <= next_brk_ch;
      bus_data_out <= next_bus;
      bus_data_oe_out <= next_oe;
    end
  end

  // vectors 40+2n and 41+2n (octal) for the break channel
  assign vector_out = `VEC_BASE + {5'h00, brk_ch, 1'b0};
  assign second_vector_out = `VEC_SECOND + {5'h00, brk_ch, 1'b0};
  assign any_request_out = any_req;
  assign channel_code_out = code;
  assign break_entry_out = break_entry_pulse;
  assign break_cycle_out = break_cycle_flag;
  assign block_done_out = block_done_flag;
  assign system_active_out = system_active_flag;
  assign honored_request_out = honored;
  assign channel_on_out = channel_on_flag;
  assign channel_hold_out = channel_hold_flag;

  // checks; after a request strobe, every on channel with a synced line is latched or held
  a_strobe_sets_req: assert property (
    (request_strobe && !system_clear_pulse) |=> ((($past(req_sync_v)
     & $past(channel_on_flag)) & ~channel_hold_flag
     & ~channel_request_latch) == '0))
    else $error("strobe did not set request");
  a_brk_blocks_strobe: assert property (
    (break_cycle_flag && !condition_set_pulse) |-> !break_entry_pulse
     ##1 ((channel_request_latch & ~$past(channel_request_latch)) == '0))
    else $error("sampling during break cycle");
  a_one_honored: assert property (
    $onehot0(honored) && (system_active_flag || honored == '0)
     && (honored == '0 || ((channel_request_latch | channel_hold_flag)
     & (honored - 7'h01)) == '0))
    else $error("wrong or several honored requests");
  a_hold_clears_req: assert property (
    |(channel_hold_flag & channel_request_latch) == 1'b0)
    else $error("request set while held");
  a_entry_sets_cyc: assert property (
    (break_entry_pulse && !system_clear_pulse) |=> break_cycle_flag
     && vector_out == `VEC_BASE + {5'h00, $past(code), 1'b0})
    else $error("break entry failed");
  a_clear_all: assert property (
    system_clear_pulse |=> !system_active_flag && channel_on_flag == '0
     && channel_hold_flag == '0 && channel_request_latch == '0)
    else $error("system clear incomplete");
  a_active_set: assert property (
    (condition_set_pulse && cmd.act_set && !cmd.act_clr
     && !system_clear_pulse) |=> system_active_flag)
    else $error("active flag not set");
  sequence s_brk_end;
    exec_step_ten_in && break_cycle_flag && !system_clear_pulse;
  endsequence
  a_step_ten_ends: assert property (
    s_brk_end |=> !break_cycle_flag && !block_done_flag)
    else $error("step ten did not end break");
  a_condition_in_command_status: assert property (
    (selected && condition_in_command_in) |=> bus_data_oe_out
     && bus_data_out[`STAT_ACT_BIT] == $past(system_active_flag))
    else $error("status word wrong");
endmodule : prio_irq
`default_nettype wire

// ==== prio_irq_cfg.svh ====
/*
  Constants for the seven-channel priority interrupt controller:
  bus bit positions, channel count, device code, vector bases.
  Assumes inclusion by bare name wherever these names are needed.
*/
`ifndef PRIO_IRQ_CFG_SVH
`define PRIO_IRQ_CFG_SVH
`define NUM_CH 7
`define CH_CODE_W 3
`define BUS_W 36
`define DEV_CODE_W 7
`define PI_DEV_CODE 7'h04
`define BIT_RESET 23
`define BIT_REQ 24
`define BIT_ON 25
`define BIT_OFF 26
`define BIT_ACT_CLR 27
`define BIT_ACT_SET 28
`define BIT_SEL_LO 29
`define STAT_ACT_BIT 28
`define VEC_W 9
`define VEC_BASE 9'h020
`define VEC_SECOND 9'h021
`endif

// ==== prio_irq_pkg.sv ====
/*
  Types shared by the priority interrupt controller files.
  Assumes prio_irq_cfg.svh is on the include path.
*/
`default_nettype none
`include "prio_irq_cfg.svh"
package prio_irq_pkg;
  // one bit per channel, bit 0 is channel 1
  typedef logic [`NUM_CH-1:0] ch_vec_t;
  // condition-out operation decoded from the bus word
  typedef struct packed {
    logic clear_all;
    logic req;
    logic on;
    logic off;
    logic act_clr;
    logic act_set;
    ch_vec_t sel;
  } condition_out_command_t;
  // break sequence states
  typedef enum logic [1:0] {
    IDLE,
    IN_BREAK
  } brk_state_t;
endpackage : prio_irq_pkg
`default_nettype wire

// ==== req_sync.sv ====
/*
  Two-stage synchroniser for the seven device request lines.
  Assumes lines may change at any time relative to mclk_in.
*/
`default_nettype none
`include "prio_irq_cfg.svh"
module req_sync (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // lines
  input wire prio_irq_pkg::ch_vec_t raw_in,
  output prio_irq_pkg::ch_vec_t sync_out
);
  prio_irq_pkg::ch_vec_t stage1;
  prio_irq_pkg::ch_vec_t stage2;
  prio_irq_pkg::ch_vec_t next_stage1;
  prio_irq_pkg::ch_vec_t next_stage2;

  // next values of the two stages
  always_comb
  begin
    next_stage1 = raw_in;
    next_stage2 = stage1;
  end

  // stage registers; stage1 feeds only stage2
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      stage1 <= '0;
      stage2 <= '0;
    end
    else
    begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign sync_out = stage2;
endmodule : req_sync
`default_nettype wire

// ==== tb_prio_irq.sv ====
/*
  Self-checking bench for the priority interrupt controller.
  Assumes single-cycle step pulses and two modelled device units.
*/
`default_nettype none
module tb_prio_irq;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CLR = 0, SET = 1, CI = 2, INS = 3, ADR = 4, DSY = 5;
  localparam int BST = 6, B2D = 7, EX0 = 8, EX1 = 9, EX10 = 10, DIS = 11;
  logic mclk, nrst, ovf, notdone, need_a, need_b;
  logic [11:0] p;
  logic [2:0] asg_a, asg_b;
  logic [6:0] dev_code;
  logic [35:0] bus_in, bus_out;
  logic oe, any, entry, bend, cyc, done, act;
  logic [2:0] code;
  logic [8:0] vec, vec2;
  prio_irq_pkg::ch_vec_t line_a, line_b, hon, ons, holds;
  int errors, check_count, cycles;
  dev_ctl_model dev_a (.assign_in(asg_a), .need_in(need_a),
    .line_out(line_a));
  dev_ctl_model dev_b (.assign_in(asg_b), .need_in(need_b),
    .line_out(line_b));
  prio_irq prio_irq_i (.mclk_in(mclk), .nrst_in(nrst),
    .dev_req_in(line_a | line_b), .dev_code_in(dev_code),
    .condition_out_command_clear_in(p[CLR]), .condition_out_command_set_in(p[SET]), .condition_in_command_in(p[CI]),
    .bus_data_in(bus_in), .bus_data_out(bus_out), .bus_data_oe_out(oe),
    .instr_start_in(p[INS]), .addr_start_in(p[ADR]),
    .delayed_sync_in(p[DSY]), .block_step_in(p[BST]),
    .block_to_data_in(p[B2D]), .index_overflow_in(ovf),
    .block_not_done_in(notdone), .exec_step_zero_in(p[EX0]),
    .exec_step_one_in(p[EX1]), .exec_step_ten_in(p[EX10]),
    .hold_dismiss_in(p[DIS]), .any_request_out(any),
    .channel_code_out(code), .vector_out(vec), .second_vector_out(vec2),
    .break_entry_out(entry), .block_end_out(bend),
    .break_cycle_out(cyc), .block_done_out(done),
    .system_active_out(act), .honored_request_out(hon),
    .channel_on_out(ons), .channel_hold_out(holds));
  // free-running clock
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // compare one value and count
  task check(input string what, input logic [35:0] seen,
    input logic [35:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // verdict
  task tally_and_finish();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  // hang guard
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      tally_and_finish();
    end
  end
  // one bus bit, and the select bit of channel n
  function automatic logic [35:0] bw(input int b);
    bw = 36'h1 << b;
  endfunction : bw
  function automatic logic [35:0] sel(input int n);
    sel = 36'h1 << (28 + n);
  endfunction : sel
  // pulse inputs high for one cycle
  task drive(input logic [11:0] m);
    p = m;
  endtask : drive
  // pulses and bus word drop on the edge, the next drive comes 1 ns later
  task tick();
    @(posedge mclk);
    p <= 12'h000;
    bus_in <= 36'h0;
    #1;
  endtask : tick
  task pulse(input int i);
    drive(12'h001 << i);
    tick();
  endtask : pulse
  // condition-out, clear or set phase
  task condition_out_command(input logic [35:0] w, input int ph);
    bus_in = w;
    pulse(ph);
  endtask : condition_out_command
  initial
  begin
    nrst = 1'b0; p = 12'h000; ovf = 1'b0; notdone = 1'b0;
    need_a = 1'b0; need_b = 1'b0; asg_a = 3'h4; asg_b = 3'h6;
    dev_code = 7'h04; bus_in = 36'h0; errors = 0; check_count = 0;
    cycles = 0;
    repeat (8) @(posedge mclk);
    #1 check("vector in reset", 36'(vec), 36'h020);
    check("active in reset", 36'(act), 36'h0);
    nrst = 1'b1;
    repeat (3) @(posedge mclk);
    #1 condition_out_command(bw(28) | bw(25) | sel(4), SET);
    pulse(CI);
    check("status", bus_out, bw(28) | sel(4));
    check("status oe", 36'(oe), 36'h1);
    // other device code: ignored
    dev_code = 7'h05;
    condition_out_command(bw(25) | sel(1), SET);
    pulse(CI);
    check("foreign oe", 36'(oe), 36'h0);
    check("foreign on", 36'(ons), 36'h08);
    dev_code = 7'h04;
    // device request on channel 4
    need_a = 1'b1;
    repeat (3) tick();
    pulse(INS);
    need_a = 1'b0;
    check("honored", 36'(hon), 36'h08);
    check("code", 36'(code), 36'h4);
    drive(12'h001 << DSY);
    #1 check("entry", 36'(entry), 36'h1);
    tick();
    check("cycle", 36'(cyc), 36'h1);
    check("vector", 36'(vec), 36'h028);
    drive(12'h001 << DSY);
    #1 check("entry in break", 36'(entry), 36'h0);
    tick();
    pulse(EX0);
    check("hold", 36'(holds), 36'h08);
    check("any held", 36'(any), 36'h0);
    check("second vector", 36'(vec2), 36'h029);
    pulse(EX10);
    check("cycle end", 36'(cyc), 36'h0);
    // program requests above and below the held break
    condition_out_command(bw(24) | sel(2) | sel(5), SET);
    check("preempt", 36'(hon), 36'h02);
    pulse(DSY);
    check("vector ch2", 36'(vec), 36'h024);
    pulse(EX0);
    pulse(EX10);
    check("two holds", 36'(holds), 36'h0A);
    check("ch5 blocked", 36'(any), 36'h0);
    pulse(DIS);
    check("dismiss one", 36'(holds), 36'h08);
    check("still blocked", 36'(any), 36'h0);
    pulse(DIS);
    check("dismiss two", 36'(holds), 36'h00);
    check("ch5 code", 36'(code), 36'h5);
    // block move step finds the request
    drive((12'h001 << BST) | (12'h001 << DSY));
    #1 check("block end", 36'(bend), 36'h1);
    check("no entry", 36'(entry), 36'h0);
    tick();
    pulse(DSY);
    check("vector ch5", 36'(vec), 36'h02A);
    // unfinished block: hold then dismissed at step one
    notdone = 1'b1;
    pulse(EX0);
    check("block hold", 36'(holds), 36'h10);
    pulse(EX1);
    check("block release", 36'(holds), 36'h00);
    pulse(EX10);
    check("block cycle end", 36'(cyc), 36'h0);
    // overflow: block done, break kept held
    condition_out_command(bw(24) | sel(3), SET);
    pulse(DSY);
    ovf = 1'b1;
    pulse(B2D);
    check("block done", 36'(done), 36'h1);
    pulse(EX0);
    pulse(EX1);
    check("done hold", 36'(holds), 36'h04);
    pulse(EX10);
    check("done cleared", 36'(done), 36'h0);
    ovf = 1'b0;
    notdone = 1'b0;
    pulse(DIS);
    // channel 6 off: device line not latched
    need_b = 1'b1;
    repeat (3) tick();
    pulse(ADR);
    check("off channel", 36'(any), 36'h0);
    condition_out_command(bw(25) | sel(6), SET);
    check("on only", 36'(any), 36'h0);
    pulse(ADR);
    check("ch6 code", 36'(code), 36'h6);
    need_b = 1'b0;
    condition_out_command(bw(27) | bw(28), SET);
    check("clr wins", 36'(act), 36'h0);
    check("chain off", 36'(any), 36'h0);
    condition_out_command(bw(28), SET);
    check("chain on", 36'(hon), 36'h20);
    condition_out_command(bw(26) | sel(4) | sel(6), SET);
    pulse(CI);
    check("channels off", bus_out, bw(28));
    condition_out_command(bw(23), CLR);
    check("reset active", 36'(act), 36'h0);
    check("reset honored", 36'(hon), 36'h00);
    check("reset on", 36'(ons), 36'h00);
    tally_and_finish();
  end
endmodule : tb_prio_irq
`default_nettype wire
